// >>> core/tsw_dev.sv
// Small first-in first-out buffer; DEPTH must be a power of two.
module tsw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   output logic [WIDTH-1:0]      o_out_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   // Extra pointer bit tells full from empty.
   wire empty = wr_ptr_reg == rd_ptr_reg;
   wire full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire push  = i_in_valid & ~full;
   wire pop   = i_out_ready & ~empty;
   assign o_in_ready  = ~full;
   assign o_out_valid = ~empty;
   assign o_out_data  = mem[rd_ptr_reg[AW-1:0]];
   // Storage has no reset; only the pointers carry state.
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
      end
   end
   // Pointer update.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
      end
   end
endmodule // tsw_fifo

// Switch end: frame alignment, stream timing, block programming and delay lookup.
module tsw_dev #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_reg_wr,
   input  wire logic [13:0] i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output logic [15:0]      o_reg_rdata,
   input  wire logic [7:0]  i_tx_data,
   input  wire logic        i_tx_valid,
   output logic             o_tx_ready,
   output logic             o_frame_strobe,
   output logic [9:0]       o_bp_delay,
   output logic             o_bp_from_bp,
   output logic             o_bp_conn,
   output logic             o_delay_valid,
   output logic [15:0]      o_local_in_frame,
   output logic [63:0]      o_bp_advance,
   output logic [31:0]      o_local_advance,
   output logic             o_blk_busy,
   tsw_link_if.dev          link
);
   import tsw_pkg::*;

   // Channels of delay between source and destination slot of one frame.
   function automatic logic [9:0] tput_delay(input logic [7:0] dst, input logic [7:0] src,
                                             input logic [8:0] chans, input logic [3:0] min_ch,
                                             input logic cnst);
      logic [9:0] d;
      d = {2'h0, dst} - {2'h0, src} + ((dst < src) ? {1'b0, chans} : 10'h000);
      if (cnst) begin
         d = d + {chans, 1'b0};
      end else if (d < {6'h00, min_ch}) begin
         d = d + {1'b0, chans};
      end
      return d;
   endfunction

   // Quarter-bit scaling for a local group rate; reserved code runs as 8 Mbps.
   function automatic logic [1:0] rate_shift(input logic [1:0] code);
      return (code == RATE_4M) ? 2'h1 : (code == RATE_2M) ? 2'h2 : 2'h0;
   endfunction

   logic [2:0]  clk_sync_reg;
   logic [1:0]  frm_sync_reg;
   logic [15:0] control_reg;
   logic [15:0] device_mode_select_reg;
   logic [15:0] block_program_reg;
   logic [15:0] local_input_delay_reg [NUM_LIDR];
   logic [15:0] backplane_out_advance_reg [NUM_BOAR];
   logic [15:0] local_out_advance_reg [NUM_LOAR];
   logic        blk_busy_reg;
   logic [12:0] blk_idx_reg;
   logic [15:0] bp_cm [BP_CM_DEPTH];
   logic [15:0] lc_cm [LC_CM_DEPTH];
   logic [15:0] bp_rd_reg;
   logic [15:0] lc_rd_reg;
   logic [15:0] reg_rd_reg;
   logic        rd_cm_reg;
   logic        rd_local_reg;
   logic [15:0] bp_look_reg;
   logic [7:0]  look_chan_reg;
   logic        look_vld_reg;
   logic [10:0] bit_cnt_reg;
   logic [7:0]  tx_sh_reg;
   logic [12:0] fcnt_reg;
   logic        frame_strobe_reg;
   logic        loc_clk_reg;
   logic        loc_fp_reg;
   logic [15:0] lin_reg;
   logic [9:0]  delay_reg;
   logic        from_bp_reg;
   logic        conn_reg;
   logic        delay_vld_reg;
   logic [7:0]  fifo_data;
   logic        fifo_valid;

   // The clock passes three flops and the frame two; the edge detector reads clock stages two and three only.
   always_ff @(posedge i_core_clk) begin
      clk_sync_reg <= {clk_sync_reg[1:0], link.align_clock_a};
      frm_sync_reg <= {frm_sync_reg[0], link.frame_a_n};
   end

   wire rise       = clk_sync_reg[1] & ~clk_sync_reg[2];
   wire fall       = ~clk_sync_reg[1] & clk_sync_reg[2];
   wire frame_edge = rise & ~frm_sync_reg[1];
   wire bp_16m     = device_mode_select_reg[DMS_BMS];
   wire bit_tick   = rise | (bp_16m & fall);
   wire byte_end   = bit_tick & (bit_cnt_reg[2:0] == 3'h7);
   wire load       = frame_edge | byte_end;
   wire [7:0] look_chan = frame_edge ? 8'h00 : 8'(bit_cnt_reg[10:3] + 8'h01);
   // Read the new channel on the load edge so the entry and its channel pair up.
   wire [7:0] look_idx  = load ? look_chan : look_chan_reg;

   // Register decode for the parallel port.
   wire        wr_regs  = i_reg_wr & ~i_reg_addr[13];
   wire        wr_cr    = wr_regs & (i_reg_addr == ADDR_CR);
   wire        wr_dms   = wr_regs & (i_reg_addr == ADDR_DMS);
   wire        wr_bpm   = wr_regs & (i_reg_addr == ADDR_BPM);
   wire [13:0] lidr_off = i_reg_addr - ADDR_LOCAL_INPUT_DELAY_REG;
   wire        lidr_hit = ~i_reg_addr[13] && (i_reg_addr >= ADDR_LOCAL_INPUT_DELAY_REG) &&
                          (lidr_off < 14'(NUM_LIDR));
   wire        boar_hit = i_reg_addr[13:2] == ADDR_BACKPLANE_OUT_ADVANCE_REG[13:2];
   wire        loar_hit = i_reg_addr[13:1] == ADDR_LOCAL_OUT_ADVANCE_REG[13:1];
   wire        cm_wr    = i_reg_wr & i_reg_addr[13] & ~blk_busy_reg;
   wire        cr_local = control_reg[CR_MEM_LOCAL];
   wire [12:0] cpu_bp_idx = i_reg_addr[12:0];
   wire [10:0] cpu_lc_idx = {i_reg_addr[11:8], i_reg_addr[6:0]};
   wire [15:0] reg_rd =
      (i_reg_addr == ADDR_CR)  ? control_reg :
      (i_reg_addr == ADDR_DMS) ? device_mode_select_reg :
      (i_reg_addr == ADDR_BPM) ? block_program_reg :
      lidr_hit ? local_input_delay_reg[lidr_off[2:0]] :
      boar_hit ? backplane_out_advance_reg[i_reg_addr[1:0]] :
      loar_hit ? local_out_advance_reg[i_reg_addr[0]] : 16'h0000;

   // Block fill starts only once both the mode bit and the enable bit are high.
   wire blk_go   = control_reg[CR_MBP] & block_program_reg[BPM_BPE] & ~blk_busy_reg;
   wire blk_done = blk_busy_reg & (blk_idx_reg == 13'h1FFF);
   wire [15:0] bp_fill = {block_program_reg[BPM_BBPD +: 3], 13'h0000};
   wire [15:0] lc_fill = {block_program_reg[BPM_LBPD +: 3], 13'h0000};

   // Control registers; rate fields are written only through their own bits.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         control_reg            <= REG_RESET;
         device_mode_select_reg <= REG_RESET;
      end else begin
         if (wr_cr) begin
            control_reg <= i_reg_wdata;
         end
         if (wr_dms) begin
            device_mode_select_reg <= i_reg_wdata;
         end
      end
   end

   // A new enable write wins over the self clear at the end of a fill.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         block_program_reg <= REG_RESET;
      end else if (wr_bpm) begin
         block_program_reg <= i_reg_wdata;
      end else if (blk_done) begin
         block_program_reg[BPM_BPE] <= 1'b0;
      end
   end

   // Per-stream delay and advance registers.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_LIDR; i++) local_input_delay_reg[i] <= REG_RESET;
         for (int i = 0; i < NUM_BOAR; i++) backplane_out_advance_reg[i] <= REG_RESET;
         for (int i = 0; i < NUM_LOAR; i++) local_out_advance_reg[i] <= REG_RESET;
      end else if (wr_regs) begin
         if (lidr_hit) local_input_delay_reg[lidr_off[2:0]] <= i_reg_wdata;
         if (boar_hit) backplane_out_advance_reg[i_reg_addr[1:0]] <= i_reg_wdata;
         if (loar_hit) local_out_advance_reg[i_reg_addr[0]] <= i_reg_wdata;
      end
   end

   // One entry per cycle: 8192 cycles, well inside two 5000-cycle frames.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         blk_busy_reg <= 1'b0;
         blk_idx_reg  <= 13'h0000;
      end else if (blk_go) begin
         blk_busy_reg <= 1'b1;
         blk_idx_reg  <= 13'h0000;
      end else if (blk_busy_reg) begin
         blk_busy_reg <= ~blk_done;
         blk_idx_reg  <= blk_idx_reg + 13'h0001;
      end
   end

   // Connection memories; the fill has priority and port writes during a fill are dropped.
   always_ff @(posedge i_core_clk) begin
      if (blk_busy_reg) begin
         bp_cm[blk_idx_reg] <= bp_fill;
      end else if (cm_wr & ~cr_local) begin
         bp_cm[cpu_bp_idx] <= i_reg_wdata;
      end
      bp_rd_reg   <= bp_cm[cpu_bp_idx];
      bp_look_reg <= bp_cm[{5'h00, look_idx}];
   end

   always_ff @(posedge i_core_clk) begin
      if (blk_busy_reg && blk_idx_reg[12:11] == 2'h0) begin
         lc_cm[blk_idx_reg[10:0]] <= lc_fill;
      end else if (cm_wr & cr_local) begin
         lc_cm[cpu_lc_idx] <= i_reg_wdata;
      end
      lc_rd_reg <= lc_cm[cpu_lc_idx];
   end

   // Read data follows the address by one cycle.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         reg_rd_reg   <= 16'h0000;
         rd_cm_reg    <= 1'b0;
         rd_local_reg <= 1'b0;
      end else begin
         reg_rd_reg   <= reg_rd;
         rd_cm_reg    <= i_reg_addr[13];
         rd_local_reg <= cr_local;
      end
   end
   assign o_reg_rdata = rd_cm_reg ? (rd_local_reg ? lc_rd_reg : bp_rd_reg) : reg_rd_reg;

   // Transmit bytes wait in the buffer; an empty buffer sends idle ones.
   tsw_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_tsw_fifo (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_in_data  (i_tx_data),
      .i_in_valid (i_tx_valid),
      .o_in_ready (o_tx_ready),
      .o_out_data (fifo_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(load)
   );

   // Bit counter restarts at each boundary; one bit per rise, or per edge at 16 Mbps.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         bit_cnt_reg   <= 11'h000;
         tx_sh_reg     <= IDLE_BYTE;
         look_chan_reg <= 8'h00;
         look_vld_reg  <= 1'b0;
      end else begin
         look_vld_reg <= load;
         if (load) begin
            tx_sh_reg     <= fifo_valid ? fifo_data : IDLE_BYTE;
            look_chan_reg <= look_chan;
         end else if (bit_tick) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
         if (frame_edge) begin
            bit_cnt_reg <= 11'h000;
         end else if (bit_tick) begin
            bit_cnt_reg <= bit_cnt_reg + 11'h001;
         end
      end
   end

   // Delay lookup one cycle after the memory read of the new channel.
   wire [2:0] bp_mode = bp_look_reg[CM_MODE +: 3];
   wire       is_conn = (bp_mode == MODE_VAR_NEAR) || (bp_mode == MODE_CONST_NEAR) ||
                        (bp_mode == MODE_VAR_BP) || (bp_mode == MODE_CONST_BP);
   wire       is_const = (bp_mode == MODE_CONST_NEAR) || (bp_mode == MODE_CONST_BP);
   wire [9:0] bp_delay = tput_delay(look_chan_reg, bp_look_reg[7:0],
                                    bp_16m ? CHANS_16M : CHANS_8M, MIN_CH_8M, is_const);
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         delay_reg     <= 10'h000;
         from_bp_reg   <= 1'b0;
         conn_reg      <= 1'b0;
         delay_vld_reg <= 1'b0;
      end else begin
         delay_vld_reg <= look_vld_reg;
         if (look_vld_reg) begin
            delay_reg   <= is_conn ? bp_delay : 10'h000;
            from_bp_reg <= bp_mode[1];
            conn_reg    <= is_conn;
         end
      end
   end

   // Per-stream input frame, late by a whole number of quarter bits of its group rate.
   wire [15:0] lin_hit;
   for (genvar s = 0; s < 16; s++) begin : g_lin
      wire [4:0]  code = local_input_delay_reg[s / 3][(s % 3) * 5 +: 5];
      wire [1:0]  rate = device_mode_select_reg[DMS_GRP0 + 2 * (s / 4) +: 2];
      wire [12:0] due  = 13'((32'(code) * QBIT_CYC) << rate_shift(rate));
      assign lin_hit[s] = fcnt_reg == due;
   end

   // Frame counter idles at its top value until the first boundary.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         fcnt_reg         <= 13'h1FFF;
         lin_reg          <= 16'h0000;
         frame_strobe_reg <= 1'b0;
         loc_clk_reg      <= 1'b0;
         loc_fp_reg       <= 1'b0;
      end else begin
         fcnt_reg         <= frame_edge ? 13'h0000 :
                             (fcnt_reg == 13'h1FFF) ? fcnt_reg : fcnt_reg + 13'h0001;
         lin_reg          <= lin_hit;
         frame_strobe_reg <= frame_edge;
         loc_clk_reg      <= clk_sync_reg[1];
         loc_fp_reg       <= frame_edge | (loc_fp_reg & ~rise);
      end
   end

   // Data and local clock leave on the same edge, so any lead is set by the pads.
   assign link.local_out_clock       = loc_clk_reg;
   assign link.local_out_frame_pulse = loc_fp_reg;
   assign link.backplane_stream_dev  = {31'h0000_0000, tx_sh_reg[7]};
   assign link.backplane_stream_oe   = bp_16m ? 32'h0000_0001 : 32'h0000_0001;
   assign o_frame_strobe   = frame_strobe_reg;
   assign o_bp_delay       = delay_reg;
   assign o_bp_from_bp     = from_bp_reg;
   assign o_bp_conn        = conn_reg;
   assign o_delay_valid    = delay_vld_reg;
   assign o_local_in_frame = lin_reg;
   // Codes count in fixed 7.5 ns steps whatever the rate; the pad delay line applies them.
   assign o_bp_advance    = {backplane_out_advance_reg[3], backplane_out_advance_reg[2],
                             backplane_out_advance_reg[1], backplane_out_advance_reg[0]};
   assign o_local_advance = {local_out_advance_reg[1], local_out_advance_reg[0]};
   assign o_blk_busy      = blk_busy_reg;
endmodule // tsw_dev

// >>> core/tsw_pkg.sv
package tsw_pkg;
   // Register offsets on the parallel port, address bit 13 low.
   localparam logic [13:0] ADDR_CR    = 14'h0000;
   localparam logic [13:0] ADDR_DMS   = 14'h0001;
   localparam logic [13:0] ADDR_BPM   = 14'h0002;
   localparam logic [13:0] ADDR_LOCAL_INPUT_DELAY_REG = 14'h0004;
   localparam logic [13:0] ADDR_BACKPLANE_OUT_ADVANCE_REG = 14'h001C;
   localparam logic [13:0] ADDR_LOCAL_OUT_ADVANCE_REG = 14'h0020;
   localparam int          NUM_LIDR   = 6;
   localparam int          NUM_BOAR   = 4;
   localparam int          NUM_LOAR   = 2;
   // Field positions.
   localparam int CR_MBP       = 0;
   localparam int CR_MEM_LOCAL = 1;
   localparam int DMS_BMS      = 0;
   localparam int DMS_GRP0     = 1;
   localparam int BPM_BPE      = 0;
   localparam int BPM_LBPD     = 3;
   localparam int BPM_BBPD     = 6;
   localparam int CM_MODE      = 13;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Connection memory sizes and mode codes.
   localparam int BP_CM_DEPTH = 8192;
   localparam int LC_CM_DEPTH = 2048;
   localparam logic [2:0] MODE_VAR_NEAR   = 3'h0;
   localparam logic [2:0] MODE_CONST_NEAR = 3'h1;
   localparam logic [2:0] MODE_VAR_BP     = 3'h2;
   localparam logic [2:0] MODE_CONST_BP   = 3'h3;
   // Local group rate codes.
   localparam logic [1:0] RATE_8M = 2'h0;
   localparam logic [1:0] RATE_4M = 2'h1;
   localparam logic [1:0] RATE_2M = 2'h2;
   // Throughput figures in channels.
   localparam logic [3:0] MIN_CH_8M = 4'hA;
   localparam logic [3:0] MIN_CH_4M = 4'h5;
   localparam logic [3:0] MIN_CH_2M = 4'h3;
   localparam logic [8:0] CHANS_8M  = 9'h080;
   localparam logic [8:0] CHANS_16M = 9'h100;
   // Timing.
   localparam int CORE_PERIOD_PS = 25000;
   localparam int FRAME_NS       = 125000;
   localparam int FRAME_CYC      = FRAME_NS * 1000 / CORE_PERIOD_PS;
   localparam int FRAME_PULSE_NS = 122;
   localparam int ALIGN_KHZ      = 8192;
   localparam int QBIT_PS        = 30518;
   localparam int QBIT_RAW       = QBIT_PS / CORE_PERIOD_PS;
   localparam int QBIT_CYC       = (QBIT_RAW < 1) ? 1 : QBIT_RAW;
   localparam int ADV_STEP_PS    = 7500;
   localparam int ADV_MAX_PS     = 22500;
   localparam int LEAD_MIN_NS    = 5;
   localparam int LEAD_MAX_NS    = 17;
   localparam int CLK_MARGIN_NS  = 13;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
endpackage

// >>> core/tsw_link_if.sv
// Pins between the switch and the backplane party; clock and frame come from the party.
interface tsw_link_if;
   logic        align_clock_a;
   logic        frame_a_n;
   logic [31:0] backplane_stream_dev;
   logic [31:0] backplane_stream_oe;
   logic [31:0] backplane_stream_host;
   logic        local_out_clock;
   logic        local_out_frame_pulse;
   modport dev (
      input  align_clock_a, frame_a_n,
      output backplane_stream_dev, backplane_stream_oe, local_out_clock, local_out_frame_pulse
   );
   modport host (
      output align_clock_a, frame_a_n, backplane_stream_host,
      input  backplane_stream_dev, backplane_stream_oe, local_out_clock, local_out_frame_pulse
   );
endinterface

// >>> core/tsw_host.sv
// Backplane party: makes the alignment clock and frame pulse and receives stream 0.
module tsw_host #(
   parameter int HALF = 4
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_bp_16m,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_valid,
   output logic            o_frame_start,
   tsw_link_if.host        link
);
   import tsw_pkg::*;

   logic [7:0] half_cnt_reg;
   logic       clk_reg;
   logic [9:0] per_cnt_reg;
   logic       frame_n_reg;
   logic [1:0] din_sync_reg;
   logic [7:0] rx_sh_reg;
   logic [2:0] rx_cnt_reg;
   logic       aligned_reg;
   logic [7:0] rx_data_reg;
   logic       rx_valid_reg;
   logic       frame_start_reg;

   // Divider: the clock toggles every HALF cycles; a frame is 1024 periods.
   wire       tog      = half_cnt_reg == 8'(HALF - 1);
   wire       clk_next = tog ? ~clk_reg : clk_reg;
   wire [9:0] per_next = (tog & ~clk_reg) ? per_cnt_reg + 10'h001 : per_cnt_reg;
   // Pulse is low for one full period around the boundary rise.
   wire       frm_low  = ((per_next == 10'h3FF) & ~clk_next) |
                         ((per_next == 10'h000) & clk_next);

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         half_cnt_reg    <= 8'h00;
         clk_reg         <= 1'b0;
         per_cnt_reg     <= 10'h3FE;
         frame_n_reg     <= 1'b1;
         frame_start_reg <= 1'b0;
      end else begin
         half_cnt_reg    <= tog ? 8'h00 : half_cnt_reg + 8'h01;
         clk_reg         <= clk_next;
         per_cnt_reg     <= per_next;
         frame_n_reg     <= ~frm_low;
         frame_start_reg <= tog & ~clk_reg & (per_next == 10'h000);
      end
   end

   // Clock and frame leave from flops with no extra skew against data.
   assign link.align_clock_a = clk_reg;
   assign link.frame_a_n     = frame_n_reg;
   // Upper streams are held low in 16 Mbps mode; otherwise idle ones.
   assign link.backplane_stream_host = i_bp_16m ? 32'h0000_FFFF : 32'hFFFF_FFFF;

   // Stream 0 is a pin: two flops before use.
   always_ff @(posedge i_core_clk) begin
      din_sync_reg <= {din_sync_reg[0], link.backplane_stream_dev[0]};
   end

   // Sample late in the half after the launching edge; every half at 16 Mbps.
   wire sample = tog & (i_bp_16m | ~clk_reg);
   wire first  = sample & ~clk_reg & (per_cnt_reg == 10'h000);
   wire done   = sample & aligned_reg & ~first & (rx_cnt_reg == 3'h7);

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rx_sh_reg    <= 8'h00;
         rx_cnt_reg   <= 3'h0;
         aligned_reg  <= 1'b0;
         rx_data_reg  <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= done;
         if (sample) begin
            rx_sh_reg  <= {rx_sh_reg[6:0], din_sync_reg[1]};
            rx_cnt_reg <= first ? 3'h1 : rx_cnt_reg + 3'h1;
         end
         if (first) begin
            aligned_reg <= 1'b1;
         end
         if (done) begin
            rx_data_reg <= {rx_sh_reg[6:0], din_sync_reg[1]};
         end
      end
   end

   assign o_rx_data     = rx_data_reg;
   assign o_rx_valid    = rx_valid_reg;
   assign o_frame_start = frame_start_reg;
endmodule // tsw_host

// >>> verification/tsw_checker.sv
// Link-level checks between the switch end and the backplane party.
module tsw_checker (
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic        align_clock_a,
   input wire logic        frame_a_n,
   input wire logic [31:0] backplane_stream_dev,
   input wire logic [31:0] backplane_stream_oe,
   input wire logic [31:0] backplane_stream_host,
   input wire logic        local_out_clock,
   input wire logic        local_out_frame_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, so clocking and reset are declared once.
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_fp_width;
      $fell(frame_a_n) |-> !frame_a_n[*8] ##1 frame_a_n;
   endproperty
   property p_clk_half;
      $rose(align_clock_a) |-> align_clock_a[*4] ##1 !align_clock_a;
   endproperty
   property p_boundary;
      $rose(align_clock_a) && !frame_a_n |-> ##[1:4] local_out_frame_pulse;
   endproperty
   property p_ofp_end;
      $rose(local_out_frame_pulse) |-> ##[4:12] !local_out_frame_pulse;
   endproperty
   property p_out_clk;
      $rose(align_clock_a) |-> ##[1:4] $rose(local_out_clock);
   endproperty
   property p_bit_hold;
      $changed(backplane_stream_dev[0]) |=> $stable(backplane_stream_dev[0])[*3];
   endproperty
   // The first cycle after reset may still show the reset enables.
   property p_oe_low;
      !$past(i_rst) |-> backplane_stream_oe == 32'h0000_0001;
   endproperty
   property p_upper_gnd;
      backplane_stream_host[31:16] == 16'h0000 || backplane_stream_host[31:16] == 16'hFFFF;
   endproperty
   a_fp_width: assert property (p_fp_width) else $error("frame pulse width wrong");
   a_clk_half: assert property (p_clk_half) else $error("align clock half wrong");
   a_boundary: assert property (p_boundary) else $error("boundary missed");
   a_ofp_end: assert property (p_ofp_end) else $error("out frame pulse too long");
   a_out_clk: assert property (p_out_clk) else $error("out clock not following");
   a_bit_hold: assert property (p_bit_hold) else $error("stream bit too short");
   a_oe_low: assert property (p_oe_low) else $error("stream enables wrong");
   a_upper_gnd: assert property (p_upper_gnd) else $error("upper lines mixed");
   // Main traffic seen on the wire.
   c_frame: cover property ($fell(frame_a_n));
   c_data: cover property ($changed(backplane_stream_dev[0]));
   c_ofp: cover property ($rose(local_out_frame_pulse));
endmodule // tsw_checker

// >>> verification/tdm_switch_stream_timing_tb.sv
module tdm_switch_stream_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tsw_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic [13:0] reg_addr = 14'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic [7:0]  tx_data = 8'h00;
   logic [7:0]  rx_data;
   logic        tx_valid = 1'b0;
   logic        tx_ready, rx_valid, delay_valid, bp_from_bp, bp_conn, blk_busy;
   logic [9:0]  bp_delay;
   logic [63:0] bp_adv;
   logic [31:0] loc_adv;
   logic        bp_16m = 1'b0;
   int          mismatches = 0;
   int          tests_run = 0;
   tsw_link_if link ();
   // Both ends face each other; the host follows the bench's rate flag.
   tsw_dev #(.FIFO_DEPTH(4)) i_tsw_dev (.i_core_clk(core_clk), .i_rst(rst), .i_reg_wr(reg_wr),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_tx_data(tx_data),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_frame_strobe(), .o_bp_delay(bp_delay),
      .o_bp_from_bp(bp_from_bp), .o_bp_conn(bp_conn), .o_delay_valid(delay_valid),
      .o_local_in_frame(), .o_bp_advance(bp_adv), .o_local_advance(loc_adv), .o_blk_busy(blk_busy),
      .link(link));
   tsw_host #(.HALF(4)) i_tsw_host (.i_core_clk(core_clk), .i_rst(rst), .i_bp_16m(bp_16m),
      .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_frame_start(), .link(link));
   tsw_checker i_tsw_checker (.i_core_clk(core_clk), .i_rst(rst),
      .align_clock_a(link.align_clock_a), .frame_a_n(link.frame_a_n),
      .backplane_stream_dev(link.backplane_stream_dev), .backplane_stream_oe(link.backplane_stream_oe),
      .backplane_stream_host(link.backplane_stream_host), .local_out_clock(link.local_out_clock),
      .local_out_frame_pulse(link.local_out_frame_pulse));
   // Shared compare and register access; strobes drop after one taking edge.
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk) #2;
      reg_wr = 1'b0;
      @(posedge core_clk) #2;
   endtask
   task automatic rc(input logic [13:0] a, input logic [15:0] exp, input string name);
      reg_addr = a;
      @(posedge core_clk) #2;
      chk(name, exp, reg_rdata);
   endtask
   task automatic t_regs();
      rc(ADDR_DMS, REG_RESET, "dms reset");
      wr(ADDR_DMS, 16'h006C);
      rc(ADDR_DMS, 16'h006C, "group rates");
      wr(ADDR_LOCAL_INPUT_DELAY_REG, 16'h7BDE);
      rc(ADDR_LOCAL_INPUT_DELAY_REG, 16'h7BDE, "input delay");
      wr(ADDR_BACKPLANE_OUT_ADVANCE_REG, 16'h0123);
      chk("advance", 16'h0123, bp_adv[15:0]);
      wr(ADDR_LOCAL_OUT_ADVANCE_REG + 14'h0001, 16'h4567);
      chk("local advance", 16'h4567, loc_adv[31:16]);
      wr(14'h0003, 16'hFFFF);
      rc(14'h0003, 16'h0000, "unmapped");
   endtask
   // Fill both memories, read one entry of each, then judge the delay lookups.
   task automatic t_block(input logic [2:0] bm, input logic [2:0] lm, input int lo, input int hi);
      int n;
      wr(ADDR_CR, 16'h0001);
      wr(ADDR_BPM, {7'h00, bm, lm, 3'h1});
      @(posedge core_clk) #2;
      chk("fill busy", 16'h0001, 16'(blk_busy));
      for (n = 0; blk_busy !== 1'b0 && n < 2 * FRAME_CYC; n++) @(posedge core_clk) #2;
      chk("fill time", 16'h0001, 16'(n < 2 * FRAME_CYC));
      rc(ADDR_BPM, {7'h00, bm, lm, 3'h0}, "enable clear");
      rc(14'h2105, {bm, 13'h0000}, "backplane entry");
      wr(ADDR_CR, 16'h0002);
      rc(14'h2105, {lm, 13'h0000}, "local entry");
      wr(ADDR_CR, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         for (n = 0; delay_valid !== 1'b1 && n < 200; n++) @(posedge core_clk) #2;
         chk("delay pulse", 16'h0001, 16'(delay_valid));
         chk("delay range", 16'h0001, 16'(bp_delay >= lo && bp_delay <= hi));
         chk("delay source", 16'(bm[1]), 16'(bp_from_bp));
         chk("connection", 16'h0001, 16'(bp_conn));
         @(posedge core_clk) #2;
      end
   endtask
   // Fill the buffer until refused, then expect the bytes in order at the host.
   task automatic t_tx();
      int k;
      int n;
      tx_valid = 1'b1;
      for (k = 0; k < 8 && tx_ready === 1'b1; k++) begin
         tx_data = 8'h30 + 8'(k);
         @(posedge core_clk) #2;
      end
      tx_valid = 1'b0;
      chk("buffer full", 16'h0001, 16'(k >= 4 && tx_ready === 1'b0));
      n = 0;
      for (int j = 0; j < k && n < 40000; n++) begin
         @(posedge core_clk) #2;
         if (rx_valid === 1'b1 && rx_data !== 8'hFF) begin
            chk("rx byte", 16'(8'h30 + 8'(j)), 16'(rx_data));
            j++;
         end
      end
      chk("rx done", 16'h0001, 16'(n < 40000));
   endtask
   task automatic results();
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Free-running core clock at 40 MHz.
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // Main sequence; links are trusted a few cycles after reset.
   initial begin
      repeat (5) @(posedge core_clk);
      #2;
      rst = 1'b0;
      repeat (4) @(posedge core_clk);
      #2;
      t_regs();
      t_block(MODE_VAR_NEAR, 3'h5, 10, 137);
      t_block(MODE_CONST_BP, MODE_CONST_NEAR, 256, 383);
      t_tx();
      wr(ADDR_DMS, 16'h0001);
      bp_16m = 1'b1;
      repeat (2 * FRAME_CYC) @(posedge core_clk);
      #2;
      t_tx();
      results();
   end
   // Two fills, both transmit runs and the two-frame wait fit well inside this span.
   initial begin
      #(60000 * 25);
      mismatches++;
      results();
   end
endmodule // tdm_switch_stream_timing_tb
